//--- rtl/txoh_ctrl.sv
// Transmit overhead error-injection and alarm control for one channel
//
// Contract
// - Mask bits 23..16 invert the fifth to twelfth F-bits of each M-frame.
// - Mask bits 15..8 invert the thirteenth to twentieth F-bits.
// - Mask bits 7..0 invert the last eight F-bits.
// - Each non-E3 F-bit is XORed with its mask bit before it leaves; E3 F-bits pass unchanged.
// - All mask registers and the E3 configuration register reset to zero.
// - In E3 the datalink octets go to NR when the location bit is one, else GC.
// - The all-ones enable replaces E3 output with continuous ones; here the all-zeros enable wins when both are set.
// - The all-zeros enable replaces E3 output with continuous zeros.
// - Source select one takes far-end bits from receive state, zero from MA.
// - Receive-derived FERF is one during loss of signal, AIS or frame loss.
// - Receive-derived FEBE is one when the receiver saw a BIP-8 error.
// - Register-sourced FERF and FEBE copy MA bits 7 and 6.
// - Mask bits 27..24 invert the first four F-bits.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module txoh_ctrl #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Register port
  input  wire logic [7:0]          regAddr,
  input  wire logic [7:0]          regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic [7:0]               regRdata,
  // Tagged bit stream from the framer core
  input  wire logic                inValid,
  output logic                     inReady,
  input  wire txoh_pkg::txoh_bit_s inBit,
  input  wire logic                dlBit,
  // Same-channel receiver conditions
  input  wire logic                rxLos,
  input  wire logic                rxAis,
  input  wire logic                rxLof,
  input  wire logic                rxBipErr,
  // Outbound line bit toward the line interface
  output logic                     lineValid,
  input  wire logic                lineReady,
  output logic                     lineBit,
  output logic                     dlLocNr
);
  logic [7:0]  cfg_ff, nxt_cfg;
  logic [7:0]  ma_ff, nxt_ma;
  logic [27:0] fmask_ff, nxt_fmask;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic [4:0]  fIdx_ff, nxt_fIdx;
  logic        dlSel_ff, nxt_dlSel;
  logic        outBit;
  logic        bufInReady;
  logic        bufOutData;
  logic        take;
  logic        fbitMask;
  logic        ferfVal, febeVal;
  logic [4:0]  curIdx;

  // Register writes; masks hold their value until software changes them
  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_ma    = ma_ff;
    nxt_fmask = fmask_ff;
    if (regWr) begin
      unique case (regAddr)
        txoh_pkg::ADDR_E3_CFG:  nxt_cfg = regWdata & txoh_pkg::CFG_WR_MASK;
        txoh_pkg::ADDR_MA_BYTE: nxt_ma  = regWdata;
        txoh_pkg::ADDR_FMASK_A: nxt_fmask[27:24] = regWdata[3:0];
        txoh_pkg::ADDR_FMASK_B: nxt_fmask[23:16] = regWdata;
        txoh_pkg::ADDR_FMASK_C: nxt_fmask[15:8]  = regWdata;
        txoh_pkg::ADDR_FMASK_D: nxt_fmask[7:0]   = regWdata;
        default: ;
      endcase
    end
  end

  // Read mux; data stand in the cycle after the strobe, zero if unmapped
  always_comb begin
    nxt_rdata = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        txoh_pkg::ADDR_E3_CFG:  nxt_rdata = cfg_ff;
        txoh_pkg::ADDR_MA_BYTE: nxt_rdata = ma_ff;
        txoh_pkg::ADDR_STATUS:  nxt_rdata = {3'b000, fIdx_ff};
        txoh_pkg::ADDR_FMASK_A: nxt_rdata = {4'h0, fmask_ff[27:24]};
        txoh_pkg::ADDR_FMASK_B: nxt_rdata = fmask_ff[23:16];
        txoh_pkg::ADDR_FMASK_C: nxt_rdata = fmask_ff[15:8];
        txoh_pkg::ADDR_FMASK_D: nxt_rdata = fmask_ff[7:0];
        default:                nxt_rdata = 8'h00;
      endcase
    end
  end

  // Registers reset to zero, the MA byte to 8'h10, so nothing is injected by default
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff   <= txoh_pkg::CFG_RESET;
      ma_ff    <= txoh_pkg::MA_RESET;
      fmask_ff <= {txoh_pkg::FMASKA_RESET, txoh_pkg::FMASK_RESET,
                   txoh_pkg::FMASK_RESET, txoh_pkg::FMASK_RESET};
      rdata_ff <= 8'h00;
    end else begin
      cfg_ff   <= nxt_cfg;
      ma_ff    <= nxt_ma;
      fmask_ff <= nxt_fmask;
      rdata_ff <= nxt_rdata;
    end
  end

  assign regRdata = rdata_ff;
  assign take     = inValid && bufInReady;
  assign inReady  = bufInReady;

  // F-bit position: a start flag restarts the count at the first F-bit
  always_comb begin
    curIdx   = inBit.mfStart ? 5'h00 : fIdx_ff;
    // Earliest F-bit uses the highest mask index
    fbitMask = fmask_ff[5'(txoh_pkg::FIDX_LAST - curIdx)];
    nxt_fIdx = fIdx_ff;
    if (take && inBit.kind == txoh_pkg::TXOH_FBIT) begin
      nxt_fIdx = (curIdx == txoh_pkg::FIDX_LAST) ? 5'h00 : curIdx + 5'h01;
    end else if (take && inBit.mfStart) begin
      nxt_fIdx = 5'h00;
    end
  end

  // Far-end bits: receive-derived or from the MA byte register
  always_comb begin
    if (cfg_ff[txoh_pkg::CFG_FE_SRC_BIT]) begin
      ferfVal = rxLos || rxAis || rxLof;
      febeVal = rxBipErr;
    end else begin
      ferfVal = ma_ff[txoh_pkg::MA_FERF_BIT];
      febeVal = ma_ff[txoh_pkg::MA_FEBE_BIT];
    end
  end

  // Output bit selection; the far-end slot pair is FERF then FEBE
  always_comb begin
    nxt_dlSel    = dlSel_ff;
    outBit       = inBit.dat;
    unique case (inBit.kind)
      txoh_pkg::TXOH_FBIT: begin
        outBit = inBit.isE3 ? inBit.dat : (inBit.dat ^ fbitMask);
      end
      txoh_pkg::TXOH_DLINK: begin
        // Datalink bit only fills the slot that the location bit picks
        if (inBit.isNr == cfg_ff[txoh_pkg::CFG_DL_LOC_BIT]) begin
          outBit = dlBit;
        end
      end
      txoh_pkg::TXOH_FARBITS: begin
        outBit = inBit.dat ? ferfVal : febeVal;
      end
      default: outBit = inBit.dat;
    endcase
    // Alarm patterns override everything in E3; zeros wins over ones
    if (inBit.isE3 && cfg_ff[txoh_pkg::CFG_ZEROS_BIT]) begin
      outBit = 1'b0;
    end else if (inBit.isE3 && cfg_ff[txoh_pkg::CFG_ONES_BIT]) begin
      outBit = 1'b1;
    end
    if (take) begin
      nxt_dlSel = cfg_ff[txoh_pkg::CFG_DL_LOC_BIT];
    end
  end

  // Frame position and datalink location state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fIdx_ff     <= 5'h00;
      dlSel_ff    <= 1'b0;
    end else begin
      fIdx_ff     <= nxt_fIdx;
      dlSel_ff    <= nxt_dlSel;
    end
  end

  assign dlLocNr = dlSel_ff;

  // Buffer keeps a word when the line interface stalls
  txoh_skid_buffer #(
    .WIDTH (1),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk      (clk),
    .arst_n   (arst_n),
    .inValid  (inValid),
    .inReady  (bufInReady),
    .inData   (outBit),
    .outValid (lineValid),
    .outReady (lineReady),
    .outData  (bufOutData)
  );

  assign lineBit = bufOutData;
endmodule : txoh_ctrl

//--- rtl/txoh_pkg.sv
// Package: register map, field positions, reset values and carrier types
package txoh_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] ADDR_E3_CFG   = 8'h30;
  localparam logic [7:0] ADDR_MA_BYTE  = 8'h31;
  localparam logic [7:0] ADDR_STATUS   = 8'h32;
  localparam logic [7:0] ADDR_FMASK_A  = 8'h36;
  localparam logic [7:0] ADDR_FMASK_B  = 8'h37;
  localparam logic [7:0] ADDR_FMASK_C  = 8'h38;
  localparam logic [7:0] ADDR_FMASK_D  = 8'h39;
  // Field positions in the E3 configuration register
  localparam int CFG_DL_LOC_BIT   = 4;
  localparam int CFG_ONES_BIT     = 2;
  localparam int CFG_ZEROS_BIT    = 1;
  localparam int CFG_FE_SRC_BIT   = 0;
  localparam logic [7:0] CFG_WR_MASK = 8'h17;
  // Field positions in the MA byte register
  localparam int MA_FERF_BIT      = 7;
  localparam int MA_FEBE_BIT      = 6;
  // Reset values
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [7:0] MA_RESET     = 8'h10;
  localparam logic [7:0] FMASK_RESET  = 8'h00;
  localparam logic [3:0] FMASKA_RESET = 4'h0;
  // Frame structure
  localparam int FBITS_PER_MFRAME = 28;
  localparam int FIDX_W           = 5;
  localparam logic [4:0] FIDX_LAST = 5'h1B;

  // Kind of the bit presented by the framer core
  typedef enum logic [1:0] {
    TXOH_PAYLOAD,
    TXOH_FBIT,
    TXOH_DLINK,
    TXOH_FARBITS
  } txoh_kind_e;

  // One outbound line bit with its tag
  typedef struct packed {
    txoh_kind_e kind;
    logic       mfStart;
    logic       isE3;
    logic       dat;
    logic       isNr;
  } txoh_bit_s;
endpackage : txoh_pkg

//--- rtl/txoh_skid_buffer.sv
// Two-entry valid/ready buffer carrying one line bit
`timescale 1ns/1ps
module txoh_skid_buffer #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [PW-1:0]    wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [PW:0]      count_ff, nxt_count;
  logic             doWr, doRd;

  // Honest full and empty from the fill count
  always_comb begin
    inReady  = (count_ff != (PW+1)'(DEPTH));
    outValid = (count_ff != '0);
    outData  = mem_ff[rdPtr_ff];
    doWr     = inValid && inReady;
    doRd     = outValid && outReady;
    nxt_mem  = mem_ff;
    if (doWr) begin
      nxt_mem[wrPtr_ff] = inData;
    end
    nxt_wrPtr = doWr ? ((wrPtr_ff == PW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1)
                     : wrPtr_ff;
    nxt_rdPtr = doRd ? ((rdPtr_ff == PW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1)
                     : rdPtr_ff;
    nxt_count = count_ff + (PW+1)'(doWr) - (PW+1)'(doRd);
  end

  // Storage and pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      mem_ff   <= nxt_mem;
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end
endmodule : txoh_skid_buffer

//--- testbench/txoh_ctrl_props.sv
// Port checker for the transmit overhead controller
`timescale 1ns/1ps
module txoh_ctrl_props (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       inValid,
  input wire logic       inReady,
  input wire txoh_pkg::txoh_bit_s inBit,
  input wire logic       rxLos,
  input wire logic       rxAis,
  input wire logic       rxLof,
  input wire logic       rxBipErr,
  input wire logic       lineValid,
  input wire logic       lineReady,
  input wire logic       lineBit,
  input wire logic       dlLocNr
);
  logic [7:0] cfgFf, maFf;
  logic       farMa, farRx;
  logic       dlFf;
  // Shadow config and MA byte, so checks do not lean on the design's copy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cfgFf <= txoh_pkg::CFG_RESET;
    else if (regWr && regAddr == txoh_pkg::ADDR_E3_CFG) cfgFf <= regWdata;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) maFf <= txoh_pkg::MA_RESET;
    else if (regWr && regAddr == txoh_pkg::ADDR_MA_BYTE) maFf <= regWdata;
  end
  // Location bit as it stood at the last accepted stream bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) dlFf <= 1'b0;
    else if (inValid && inReady) dlFf <= cfgFf[txoh_pkg::CFG_DL_LOC_BIT];
  end
  // Expected far-end bit for the slot on offer
  assign farMa = inBit.dat ? maFf[7] : maFf[6];
  assign farRx = inBit.dat ? (rxLos | rxAis | rxLof) : rxBipErr;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // E3 bit taken into an empty buffer, so it is the next head
  sequence s_take_e3; inValid && inReady && !lineValid && inBit.isE3; endsequence
  sequence s_far; s_take_e3 ##0 inBit.kind == txoh_pkg::TXOH_FARBITS
    && cfgFf[2:1] == 2'h0; endsequence
  property p_rd_idle; !$past(regRd) |-> regRdata == 8'h00; endproperty
  property p_rd_cfg; regRd && regAddr == txoh_pkg::ADDR_E3_CFG
    |=> regRdata == (cfgFf & txoh_pkg::CFG_WR_MASK); endproperty
  property p_hold; lineValid && !lineReady |=> lineValid && $stable(lineBit);
  endproperty
  property p_ones; s_take_e3 ##0 cfgFf[2:1] == 2'h2 |=> lineBit; endproperty
  property p_zeros; s_take_e3 ##0 cfgFf[1] |=> !lineBit; endproperty
  property p_far_ma; s_far ##0 !cfgFf[0] |=> lineBit == $past(farMa);
  endproperty
  property p_far_rx; s_far ##0 cfgFf[0] |=> lineBit == $past(farRx);
  endproperty
  property p_dl_loc; dlLocNr == dlFf; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_rd_cfg: assert property (p_rd_cfg)
    else $error("config readback wrong");
  a_hold: assert property (p_hold)
    else $error("line bit moved while stalled");
  a_ones: assert property (p_ones)
    else $error("all-ones pattern missing");
  a_zeros: assert property (p_zeros)
    else $error("all-zeros pattern missing");
  a_far_ma: assert property (p_far_ma)
    else $error("far-end bit not from MA byte");
  a_far_rx: assert property (p_far_rx)
    else $error("far-end bit not from receiver");
  a_dl_loc: assert property (p_dl_loc)
    else $error("datalink location output wrong");
endmodule : txoh_ctrl_props

bind txoh_ctrl txoh_ctrl_props i_txoh_ctrl_props (.clk, .arst_n, .regAddr,
  .regWdata, .regWr, .regRd, .regRdata, .inValid, .inReady, .inBit, .rxLos,
  .rxAis, .rxLof, .rxBipErr, .lineValid, .lineReady, .lineBit, .dlLocNr);

//--- testbench/txoh_line_model.sv
// Line interface model that takes outbound bits and can stall
`timescale 1ns/1ps
module txoh_line_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic lineValid,
  input  wire logic lineBit,
  input  wire logic slow,
  output logic      lineReady,
  output logic      rxStb,
  output logic      rxBit
);
  logic [1:0] phaseFf;
  // Free phase counter; slow mode takes one bit in four to fill the buffer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) phaseFf <= 2'h0;
    else phaseFf <= phaseFf + 2'h1;
  end
  assign lineReady = !slow || phaseFf == 2'h0;
  assign rxStb = lineValid && lineReady;
  assign rxBit = lineBit;
endmodule : txoh_line_model

//--- testbench/testbench.sv
// Self-checking bench for the transmit overhead controller
`timescale 1ns/1ps
module testbench;
  logic       clk, arst_n, regWr, regRd, inValid, inReady, dlBit, slow;
  logic       rxLos, rxAis, rxLof, rxBipErr, lineValid, lineReady;
  logic       lineBit, dlLocNr, rxStb, rxBit;
  logic [7:0] regAddr, regWdata, regRdata;
  logic       got[$];
  int         n_errors, compares;
  txoh_pkg::txoh_bit_s inBit;
  txoh_ctrl i_txoh_ctrl (.clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .inValid, .inReady, .inBit, .dlBit, .rxLos, .rxAis, .rxLof,
    .rxBipErr, .lineValid, .lineReady, .lineBit, .dlLocNr);
  txoh_line_model i_txoh_line_model (.clk, .arst_n, .lineValid, .lineBit,
    .slow, .lineReady, .rxStb, .rxBit);
  // 40 MHz clock; received bits collected from the line model
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (rxStb) got.push_back(rxBit);
  task automatic chk(string what, logic [7:0] exp, logic [7:0] act);
    compares++;
    if (act !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, act);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("regRdata", exp, regRdata);
  endtask : rd
  // Hold the bit until the edge where inReady is seen high
  task automatic send(txoh_pkg::txoh_bit_s b);
    int k = 0;
    @(posedge clk);
    inValid <= 1'b1;
    inBit <= b;
    do begin
      @(negedge clk);
      k++;
    end while (!inReady && k < 200);
    @(posedge clk);
    inValid <= 1'b0;
  endtask : send
  task automatic take(logic exp);
    for (int k = 0; k < 50 && got.size() == 0; k++) @(posedge clk);
    if (got.size() == 0) got.push_back(1'bx);
    chk("lineBit", {7'h00, exp}, {7'h00, got.pop_front()});
  endtask : take
  task automatic t_regs;
    rd(txoh_pkg::ADDR_MA_BYTE, 8'h10);
    for (int i = 0; i < 5; i++)
      rd(i < 4 ? 8'h36 + 8'(i) : txoh_pkg::ADDR_E3_CFG, 8'h00);
    rd(8'h3F, 8'h00);
    wr(txoh_pkg::ADDR_E3_CFG, 8'hFF);
    rd(txoh_pkg::ADDR_E3_CFG, txoh_pkg::CFG_WR_MASK);
    wr(txoh_pkg::ADDR_FMASK_A, 8'hFF);
    rd(txoh_pkg::ADDR_FMASK_A, 8'h0F);
  endtask : t_regs
  task automatic t_fbits(logic [27:0] m, logic sl);
    slow <= sl;
    wr(txoh_pkg::ADDR_FMASK_A, {4'h0, m[27:24]});
    wr(txoh_pkg::ADDR_FMASK_B, m[23:16]);
    wr(txoh_pkg::ADDR_FMASK_C, m[15:8]);
    wr(txoh_pkg::ADDR_FMASK_D, m[7:0]);
    got.delete();
    for (int n = 0; n < 28; n++) send('{txoh_pkg::TXOH_FBIT, n == 0, 0, n[0], 0});
    for (int k = 0; k < 400 && got.size() < 28; k++) @(posedge clk);
    for (int n = 0; n < 28; n++)
      chk("fbit", {7'h00, n[0] ^ m[27-n]}, {7'h00, got[n]});
    got.delete();
    slow <= 1'b0;
  endtask : t_fbits
  task automatic t_alarm;
    logic [7:0] c[4] = '{8'h04, 8'h02, 8'h06, 8'h00};
    logic [1:0] e[4] = '{2'h3, 2'h0, 2'h0, 2'h2};
    for (int i = 0; i < 4; i++) begin
      wr(txoh_pkg::ADDR_E3_CFG, c[i]);
      for (int d = 0; d < 2; d++) begin
        send('{txoh_pkg::TXOH_PAYLOAD, 0, 1, d[0], 0});
        take(e[i][d]);
      end
    end
  endtask : t_alarm
  task automatic t_dlink;
    for (int l = 0; l < 2; l++) begin
      wr(txoh_pkg::ADDR_E3_CFG, l[0] ? 8'h10 : 8'h00);
      for (int r = 0; r < 2; r++) begin
        send('{txoh_pkg::TXOH_DLINK, 0, 1, 0, r[0]});
        take(l[0] == r[0]);
      end
      chk("dlLocNr", {7'h00, l[0]}, {7'h00, dlLocNr});
    end
  endtask : t_dlink
  task automatic t_far;
    logic [3:0] r;
    for (int i = 0; i < 7; i++) begin
      r = 4'h1 << (i - 2);
      if (i < 3) wr(i < 2 ? txoh_pkg::ADDR_MA_BYTE : txoh_pkg::ADDR_E3_CFG,
        i == 0 ? 8'h80 : i == 1 ? 8'h40 : 8'h01);
      @(posedge clk);
      {rxLos, rxAis, rxLof, rxBipErr} <= (i < 2) ? 4'hF : r;
      for (int d = 0; d < 2; d++) begin
        send('{txoh_pkg::TXOH_FARBITS, 0, 1, d[0], 0});
        take(i < 2 ? d == (i == 0) : d ? |r[3:1] : r[0]);
      end
    end
  endtask : t_far
  task automatic report_and_stop;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // Watchdog cuts a hang short after about 40000 cycles
  initial begin
    #1_000_000;
    n_errors++;
    report_and_stop;
  end
  // Reset for five cycles, then the scenarios in turn
  initial begin
    {arst_n, regWr, regRd, inValid, slow, rxLos, rxAis, rxLof} = '0;
    {rxBipErr, regAddr, regWdata, inBit} = '0;
    dlBit = 1'b1;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_fbits(28'h9A5_3CE1, 1'b1);
    t_fbits(28'h000_0000, 1'b0);
    t_alarm;
    t_dlink;
    t_far;
    report_and_stop;
  end
endmodule : testbench
